/* logic/cmt_timer.v */
// Purpose: one channel of a periodic compare-match timer behind an apb slave
// Assumes: single clock pclk at 200 MHz, apb master, standby as a level input
// Notes: standby reinitialises registers; manual reset is not modelled as a reset
//
// Notes on behaviour
// (RULE_01) the period register is 16 bits and readable and writable by software.
// (RULE_02) the period register loads all ones on power-on reset and standby, not on manual reset.
// (RULE_03) the counter steps on the selected prescaled tick once the run bit is 1.
// (RULE_04) on a match with the period register the counter clears and the match flag sets.
// (RULE_05) after a match clear counting resumes from zero, period is value plus one.
// (RULE_06) the counter tick is the system clock divided by 8, 32, 128 or 512.
// (RULE_07) the interrupt request is high only while match flag and enable are both 1.
// (RULE_08) the match request also serves as a transfer controller activation source.
// (RULE_09) the match flag sets on the tick that ends the matching count, not before.
// (RULE_10) the flag clears on a software 0 write after reading 1, or on a transfer clear.
// (RULE_11) a match during a counter write clears the counter and drops the write.
// (RULE_12) a word write coinciding with an increment stores the word, no increment.
// (RULE_13) a byte write coinciding with an increment keeps the other byte unincremented.
// (RULE_14) clock select 00 is /8 (reset), 01 /32, 10 /128, 11 /512.
// (RULE_15) the counter resets to zero on power-on reset and standby.
// (RULE_16) writing 1 to the match flag has no effect; only 0 clears it.
// (RULE_17) while the run bit is 0 the counter holds and no match is produced.
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
`include "cmt_consts.vh"
module cmt_timer #(
   parameter PRESC_W = `CMT_PRESC_W
) (
   input wire pclk,
   input wire presetn,
   input wire standby,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire xfer_clear,
   output reg match_irq_request,
   output reg xfer_request,
   output reg irq
);

   reg channel_run_bit_r;
   reg match_flag_r;
   reg flag_seen_r;
   reg match_irq_enable_r;
   reg [1:0] clk_select_r;
   reg [15:0] up_counter_r;
   reg [15:0] period_constant_r;
   reg [PRESC_W-1:0] presc_r;
   reg [1:0] irq_stat_r;
   reg [1:0] irq_mask_r;
   reg [15:0] cnt_nxt;
   reg tick;
   reg match;
   reg [31:0] rdata_nxt;

   wire setup = psel & ~penable;
   // writes land on the edge that completes the access, the edge at which the master sees pready
   wire access_done = psel & penable & pready;
   wire wr = access_done & pwrite;
   // reads are decoded at setup so that the registered data stands with pready
   wire rd = setup & ~pwrite;

   function hit;
      input [11:0] a;
      input [11:0] off;
      begin
         hit = (a == off);
      end
   endfunction

   // tick when the low log2(div) prescaler bits are all ones
   always @* begin
      case (clk_select_r) // RULE_14
         2'h0: tick = &presc_r[`CMT_DIV_LOG0-1:0]; // RULE_06
         2'h1: tick = &presc_r[`CMT_DIV_LOG1-1:0];
         2'h2: tick = &presc_r[`CMT_DIV_LOG2-1:0];
         2'h3: tick = &presc_r[`CMT_DIV_LOG3-1:0];
         default: tick = 1'b0;
      endcase
   end

   // match is taken on the tick that would move the counter off the matching value
   always @* begin
      match = channel_run_bit_r & tick & (up_counter_r == period_constant_r); // RULE_09 RULE_17
      cnt_nxt = up_counter_r;
      if (match) begin
         cnt_nxt = `CMT_COUNT_RST; // RULE_04 RULE_05 RULE_11
      end else if (wr && hit(paddr, `CMT_OFF_COUNT)) begin
         // write wins over increment; unwritten byte keeps its pre-write value
         if (pstrb[1]) begin
            cnt_nxt[15:8] = pwdata[15:8]; // RULE_12 RULE_13
         end
         if (pstrb[0]) begin
            cnt_nxt[7:0] = pwdata[7:0]; // RULE_13
         end
      end else if (channel_run_bit_r && tick) begin
         cnt_nxt = up_counter_r + 16'h0001; // RULE_03
      end
   end

   always @* begin
      rdata_nxt = 32'h0000_0000;
      case (paddr)
         `CMT_OFF_START: rdata_nxt[0] = channel_run_bit_r;
         `CMT_OFF_CTRL: rdata_nxt[7:0] = {match_flag_r, match_irq_enable_r, 4'h0, clk_select_r};
         `CMT_OFF_COUNT: rdata_nxt[15:0] = up_counter_r;
         `CMT_OFF_PERIOD: rdata_nxt[15:0] = period_constant_r; // RULE_01
         `CMT_OFF_IRQ_STAT: rdata_nxt[1:0] = irq_stat_r;
         `CMT_OFF_IRQ_MASK: rdata_nxt[1:0] = irq_mask_r;
         default: rdata_nxt = 32'h0000_0000;
      endcase
   end

   wire mapped = hit(paddr, `CMT_OFF_START) | hit(paddr, `CMT_OFF_CTRL) |
      hit(paddr, `CMT_OFF_COUNT) | hit(paddr, `CMT_OFF_PERIOD) |
      hit(paddr, `CMT_OFF_IRQ_STAT) | hit(paddr, `CMT_OFF_IRQ_MASK);
   wire ctrl_wr = wr & hit(paddr, `CMT_OFF_CTRL) & pstrb[0];
   // a 0 clears only if a 1 was read first; writing 1 is ignored
   wire sw_clear = ctrl_wr & ~pwdata[`CMT_BIT_FLAG] & flag_seen_r; // RULE_10 RULE_16
   wire flag_nxt = match | (match_flag_r & ~sw_clear & ~xfer_clear); // RULE_10
   wire ie_nxt = ctrl_wr ? pwdata[`CMT_BIT_IE] : match_irq_enable_r;
   // status bit 0: match event, bit 1: transfer clear seen
   wire [1:0] ev = {xfer_clear, match};
   wire [1:0] st_clr = (wr & hit(paddr, `CMT_OFF_IRQ_STAT) & pstrb[0]) ? pwdata[1:0] : 2'h0;
   wire [1:0] stat_nxt = ev | (irq_stat_r & ~st_clr);

   // apb answers in the access phase right after setup; registered outputs
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         pslverr <= setup & ~mapped;
         prdata <= rd ? rdata_nxt : 32'h0000_0000;
      end
   end

   // free-running prescaler; standby restarts it so the tick phase is known after wake-up
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         presc_r <= {PRESC_W{1'b0}};
      end else if (standby) begin
         presc_r <= {PRESC_W{1'b0}};
      end else begin
         presc_r <= presc_r + {{(PRESC_W-1){1'b0}}, 1'b1};
      end
   end

   // up-counter; contention priorities are resolved in cnt_nxt
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         up_counter_r <= `CMT_COUNT_RST; // RULE_15
      end else if (standby) begin
         up_counter_r <= `CMT_COUNT_RST; // RULE_15
      end else begin
         up_counter_r <= cnt_nxt;
      end
   end

   // period register; byte lanes let software update one half without touching the other
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         period_constant_r <= `CMT_PERIOD_RST; // RULE_02
      end else if (standby) begin
         period_constant_r <= `CMT_PERIOD_RST; // RULE_02
      end else if (wr && hit(paddr, `CMT_OFF_PERIOD)) begin
         if (pstrb[1]) begin
            period_constant_r[15:8] <= pwdata[15:8]; // RULE_01
         end
         if (pstrb[0]) begin
            period_constant_r[7:0] <= pwdata[7:0];
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         channel_run_bit_r <= 1'b0;
      end else if (standby) begin
         channel_run_bit_r <= 1'b0;
      end else if (wr && hit(paddr, `CMT_OFF_START) && pstrb[0]) begin
         channel_run_bit_r <= pwdata[0];
      end
   end

   // control/status: clock select, enable and the sticky match flag
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_select_r <= 2'h0;
         match_irq_enable_r <= 1'b0;
         match_flag_r <= 1'b0;
         flag_seen_r <= 1'b0;
      end else if (standby) begin
         clk_select_r <= 2'h0;
         match_irq_enable_r <= 1'b0;
         match_flag_r <= 1'b0;
         flag_seen_r <= 1'b0;
      end else begin
         if (ctrl_wr) begin
            clk_select_r <= pwdata[1:0];
         end
         match_irq_enable_r <= ie_nxt;
         match_flag_r <= flag_nxt;
         // the read of a 1 arms the clear; losing the flag disarms it
         if (rd && hit(paddr, `CMT_OFF_CTRL) && match_flag_r) begin
            flag_seen_r <= 1'b1;
         end else if (!flag_nxt) begin
            flag_seen_r <= 1'b0;
         end
      end
   end

   // interrupt status and mask; a new event beats a clear in the same cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_r <= 2'h0;
         irq_mask_r <= 2'h0;
      end else if (standby) begin
         irq_stat_r <= 2'h0;
         irq_mask_r <= 2'h0;
      end else begin
         irq_stat_r <= stat_nxt;
         if (wr && hit(paddr, `CMT_OFF_IRQ_MASK) && pstrb[0]) begin
            irq_mask_r <= pwdata[1:0];
         end
      end
   end

   // request outputs are registered from next values so they track the flag without a lag
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         match_irq_request <= 1'b0;
         xfer_request <= 1'b0;
         irq <= 1'b0;
      end else if (standby) begin
         match_irq_request <= 1'b0;
         xfer_request <= 1'b0;
         irq <= 1'b0;
      end else begin
         match_irq_request <= flag_nxt & ie_nxt; // RULE_07
         // fixed priority applies in the transfer controller; this is its activation line
         xfer_request <= flag_nxt & ie_nxt; // RULE_08
         // uses the mask as it stands; a new mask shows one cycle later
         irq <= |(stat_nxt & irq_mask_r);
      end
   end

endmodule // cmt_timer

/* logic/cmt_consts.vh */
// Purpose: constants for the periodic match timer channel
// Assumes: apb with 32-bit data, word-aligned registers
// Notes: offsets are byte addresses
`ifndef CMT_CONSTS_VH
`define CMT_CONSTS_VH
`define CMT_OFF_START 12'h000
`define CMT_OFF_CTRL 12'h004
`define CMT_OFF_COUNT 12'h008
`define CMT_OFF_PERIOD 12'h00c
`define CMT_OFF_IRQ_STAT 12'h010
`define CMT_OFF_IRQ_MASK 12'h014
`define CMT_PERIOD_RST 16'hffff
`define CMT_COUNT_RST 16'h0000
`define CMT_BIT_FLAG 7
`define CMT_BIT_IE 6
`define CMT_DIV_LOG0 3
`define CMT_DIV_LOG1 5
`define CMT_DIV_LOG2 7
`define CMT_DIV_LOG3 9
`define CMT_PRESC_W 9
`endif

/* test/cmt_timer_checker.sv */
// Purpose: port checks for cmt_timer
// Assumes: zero-wait apb slave
// Notes: bound after the module
`timescale 1ns/1ps
module cmt_timer_checker (
   input wire pclk, input wire presetn, input wire standby,
   input wire psel, input wire penable, input wire [11:0] paddr,
   input wire [31:0] prdata, input wire pready, input wire pslverr,
   input wire match_irq_request, input wire xfer_request, input wire irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_setup: assert property (psel && !penable |=> pready)
      else $error("no ready");
   a_ready_lone: assert property (pready |-> psel && penable ##1 !pready)
      else $error("bad ready");
   a_rdata_idle: assert property (!pready |-> prdata == 0)
      else $error("rdata not 0");
   a_err_unmapped: assert property (pready && paddr > 12'h017 |-> pslverr)
      else $error("no err");
   a_err_mapped: assert property (pready && paddr < 12'h018 && paddr[1:0] == 0 |-> !pslverr)
      else $error("bad err");
   a_err_data: assert property (pready && pslverr |-> prdata == 0)
      else $error("err data");
   a_xfer_mirror: assert property (xfer_request == match_irq_request)
      else $error("xfer mismatch");
   a_standby_quiet: assert property (standby |=> !match_irq_request && !irq)
      else $error("standby");
   cover property (pready && pslverr);
   cover property ($rose(match_irq_request));
   cover property ($rose(irq));
endmodule // cmt_timer_checker
bind cmt_timer cmt_timer_checker i_cmt_timer_checker (.pclk, .presetn, .standby, .psel,
   .penable, .paddr, .prdata, .pready, .pslverr, .match_irq_request, .xfer_request, .irq);

/* test/cmt_xfer_model.sv */
// Purpose: behavioural transfer controller
// Assumes: request is a level held until cleared
// Notes: dly sets how slowly the clear returns
`timescale 1ns/1ps
module cmt_xfer_model (
   input wire pclk, input wire presetn, input wire en, input wire [3:0] dly,
   input wire xfer_request, output reg xfer_clear
);
   reg [3:0] cnt_r;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 4'h0;
         xfer_clear <= 1'b0;
      end else begin
         xfer_clear <= 1'b0;
         cnt_r <= 4'h0;
         // gated on the pulse so one request gets one clear
         if (en && xfer_request && !xfer_clear) begin
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == dly) xfer_clear <= 1'b1;
         end
      end
   end
endmodule // cmt_xfer_model

/* test/cmt_timer_tb.sv */
// Purpose: directed bench for cmt_timer
// Assumes: zero-wait apb, period 3 keeps runs short
// Notes: transfer model clears the flag in the divider sweep
`timescale 1ns/1ps
`include "cmt_consts.vh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
   $display("mismatch %s exp %h got %h", n, e, g); end end
module cmt_timer_tb;
   reg pclk = 0, presetn = 0, standby = 0, psel = 0, penable = 0, pwrite = 0, xen = 0;
   reg ev, mir_d = 0;
   reg [11:0] paddr = 0;
   reg [31:0] pwdata = 0, rv, t;
   reg [3:0] pstrb = 0, dly = 0;
   wire [31:0] prdata;
   wire pready, pslverr, xfer_clear, mir, xreq, irq;
   int fails = 0, checks_done = 0, cyc = 0, k;
   cmt_timer i_cmt_timer (.pclk, .presetn, .standby, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pstrb, .prdata, .pready, .pslverr, .xfer_clear,
      .match_irq_request(mir), .xfer_request(xreq), .irq);
   cmt_xfer_model i_cmt_xfer_model (.pclk, .presetn, .en(xen), .dly,
      .xfer_request(xreq), .xfer_clear);
   initial forever #2.5 pclk = ~pclk;
   task end_of_test;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // request held until pready is seen at an edge
   task apb(input [11:0] a, input w, input [31:0] d, input [3:0] s);
      @(posedge pclk);
      psel <= 1; paddr <= a; pwrite <= w; pwdata <= d; pstrb <= s;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rv = prdata; ev = pslverr;
      psel <= 0; penable <= 0;
   endtask
   task wr(input [11:0] a, input [31:0] d); apb(a, 1, d, 4'hf); endtask
   task rd(input [11:0] a); apb(a, 0, 0, 4'h0); endtask
   task rise; do @(posedge pclk); while (!(mir === 1'b1 && mir_d === 1'b0)); endtask
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      mir_d <= mir;
      if (cyc == 20000) begin fails++; end_of_test; end
   end
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1;
      rd(`CMT_OFF_PERIOD); `CHK("period rst", 32'hffff, rv)
      rd(`CMT_OFF_COUNT); `CHK("count rst", 32'h0, rv)
      rd(`CMT_OFF_CTRL); `CHK("ctrl rst", 32'h0, rv)
      rd(12'h020); `CHK("unmapped", 1'b1, ev)
      wr(`CMT_OFF_PERIOD, 3); rd(`CMT_OFF_PERIOD); `CHK("period rw", 32'h3, rv)
      wr(`CMT_OFF_CTRL, 32'hc0); rd(`CMT_OFF_CTRL); `CHK("flag w1", 32'h40, rv)
      wr(`CMT_OFF_START, 1); rise; rd(`CMT_OFF_CTRL); `CHK("flag set", 32'hc0, rv)
      wr(`CMT_OFF_CTRL, 32'h40); repeat (2) @(posedge pclk);
      `CHK("req drop", 1'b0, mir)
      rd(`CMT_OFF_CTRL); `CHK("flag clr", 32'h40, rv)
      xen <= 1;
      for (k = 0; k < 4; k++) begin
         dly <= 4'(k * 3);
         wr(`CMT_OFF_CTRL, 32'h40 | k);
         rise; t = cyc; rise;
         `CHK("period", 4 * (8 << (2 * k)), cyc - t)
      end
      wr(`CMT_OFF_START, 0); xen <= 0;
      `CHK("masked", 1'b0, irq)
      wr(`CMT_OFF_IRQ_MASK, 1); repeat (2) @(posedge pclk); `CHK("irq", 1'b1, irq)
      wr(`CMT_OFF_IRQ_STAT, 3); repeat (2) @(posedge pclk); `CHK("irq clr", 1'b0, irq)
      rd(`CMT_OFF_COUNT); t = rv; repeat (40) @(posedge pclk);
      rd(`CMT_OFF_COUNT); `CHK("hold", t, rv)
      wr(`CMT_OFF_COUNT, 32'h1234); apb(`CMT_OFF_COUNT, 1, 32'h56, 4'h1);
      rd(`CMT_OFF_COUNT); `CHK("byte", 32'h1256, rv)
      standby <= 1; @(posedge pclk); standby <= 0;
      rd(`CMT_OFF_PERIOD); `CHK("stby period", 32'hffff, rv)
      rd(`CMT_OFF_COUNT); `CHK("stby count", 32'h0, rv)
      end_of_test;
   end
endmodule // cmt_timer_tb
